// >>> pkg/xroute_pkg.sv
// constants for the serial and infrared crosspoint of the extender
// Contract
// - Each local serial connector is one source (its transmit data) and one destination (its receive line).
// - Every byte taken on a local serial input is forwarded toward the remote unit whatever the local routing is; with link_en low they are dropped.
// - The link is never a destination; each remote serial input shows up locally as an extra source.
// - The source of each local serial destination is chosen by local configuration only.
// - Serial sources number local plus remote ports; serial destinations number local ports only.
// - Routing a connector's own source to its destination loops its transmit data back to its receive line.
// - A path exchanges serial data between the local lines and the local IP control port for injection.
// - Traffic toward a unit flows only when that unit has its link enabled.
// - With several serial modules fitted the same routing is replicated per port.
// - All local infrared input is forwarded to the remote unit at all times.
// - Infrared sources number local plus remote inputs; destinations number local outputs only.
// - The source of a local infrared output is chosen by configuration held in this unit.
// - A local infrared input can be routed straight to a local infrared output as a loopback.
// - The IP port can inject infrared onto local outputs and capture local infrared inputs.
package xroute_pkg;
    // ------------------------------------------------------------
    // port counts
    // ------------------------------------------------------------
    localparam int N_SER = 2;
    localparam int N_SER_REM = 2;
    localparam int N_SER_SRC = N_SER + N_SER_REM;
    localparam int N_IR_IN = 2;
    localparam int N_IR_REM = 2;
    localparam int N_IR_SRC = N_IR_IN + N_IR_REM;
    localparam int N_IR_OUT = 2;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PORT_W = 1;
    localparam int SRC_W = 2;
    localparam int LINK_W = PORT_W + DATA_W;
    localparam int FIFO_DEPTH = 8;
    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [SRC_W-1:0] SEL_RST = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [PORT_W-1:0] PORT_RST = 1'h0;
endpackage

// >>> design/link_fifo.sv
// flop-based fifo with valid/ready on both sides
`timescale 1ns/1ns
module link_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_state_type;
    fifo_state_type st_q;
    fifo_state_type st_d;
    logic push;
    logic pop;

    assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_q.cnt != '0);
    assign out_data = st_q.mem[st_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: st_d.cnt = st_q.cnt + 1'b1;
            2'b01: st_d.cnt = st_q.cnt - 1'b1;
            default: st_d.cnt = st_q.cnt;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // link_fifo

// >>> design/dest_sel.sv
// one destination of the crosspoint: picks a source or nothing
`timescale 1ns/1ns
module dest_sel #(
    parameter int NSRC = 4,
    parameter int SW = 2,
    parameter int W = 9
) (
    input wire logic en,
    input wire logic [SW-1:0] sel,
    input wire logic [NSRC-1:0][W-1:0] src,
    output logic [W-1:0] dout
);
    always_comb begin
        dout = '0;
        if (en && (int'(sel) < NSRC)) begin
            dout = src[sel];
        end
    end
endmodule // dest_sel

// >>> design/xroute_top.sv
// serial and infrared crosspoint between local ports, link and ip port
`timescale 1ns/1ns
module xroute_top (
    input wire logic clock,
    input wire logic rst,
    // local serial connectors
    input wire logic [xroute_pkg::N_SER-1:0] tx_valid,
    output logic [xroute_pkg::N_SER-1:0] tx_ready,
    input wire logic [xroute_pkg::N_SER-1:0][xroute_pkg::DATA_W-1:0] tx_data,
    output logic [xroute_pkg::N_SER-1:0] rx_valid,
    output logic [xroute_pkg::N_SER-1:0][xroute_pkg::DATA_W-1:0] rx_data,
    // local infrared pins
    input wire logic [xroute_pkg::N_IR_IN-1:0] ir_in,
    output logic [xroute_pkg::N_IR_OUT-1:0] ir_out,
    // link enable of this unit
    input wire logic link_en,
    // serial toward remote unit
    output logic link_valid,
    input wire logic link_ready,
    output logic [xroute_pkg::LINK_W-1:0] link_data,
    // serial from remote unit
    input wire logic rem_valid,
    input wire logic [xroute_pkg::PORT_W-1:0] rem_port,
    input wire logic [xroute_pkg::DATA_W-1:0] rem_data,
    // infrared to and from remote unit
    output logic [xroute_pkg::N_IR_IN-1:0] link_ir,
    input wire logic [xroute_pkg::N_IR_REM-1:0] rem_ir,
    // routing configuration
    input wire logic cfg_wr,
    input wire logic cfg_ir,
    input wire logic [xroute_pkg::PORT_W-1:0] cfg_dest,
    input wire logic cfg_en,
    input wire logic [xroute_pkg::SRC_W-1:0] cfg_src,
    // ip control port, serial
    input wire logic ip_valid,
    output logic ip_ready,
    input wire logic [xroute_pkg::PORT_W-1:0] ip_port,
    input wire logic [xroute_pkg::DATA_W-1:0] ip_data,
    output logic cap_valid,
    output logic [xroute_pkg::PORT_W-1:0] cap_port,
    output logic [xroute_pkg::DATA_W-1:0] cap_data,
    // ip control port, infrared
    input wire logic [xroute_pkg::N_IR_OUT-1:0] ip_ir_en,
    input wire logic [xroute_pkg::N_IR_OUT-1:0] ip_ir_data,
    output logic [xroute_pkg::N_IR_IN-1:0] ip_ir_cap
);
    localparam int NS = xroute_pkg::N_SER;
    localparam int DW = xroute_pkg::DATA_W;
    localparam int PW = xroute_pkg::PORT_W;
    localparam int SW = xroute_pkg::SRC_W;
    localparam int EW = DW + 1;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NS-1:0] hold_v;
        logic [NS-1:0][DW-1:0] hold_d;
        logic [PW-1:0] rr;
        logic [NS-1:0] ser_en;
        logic [NS-1:0][SW-1:0] ser_sel;
        logic [xroute_pkg::N_IR_OUT-1:0] ir_en;
        logic [xroute_pkg::N_IR_OUT-1:0][SW-1:0] ir_sel;
        logic ip_v;
        logic [PW-1:0] ip_p;
        logic [DW-1:0] ip_d;
        logic [NS-1:0] rx_v;
        logic [NS-1:0][DW-1:0] rx_d;
        logic [xroute_pkg::N_IR_OUT-1:0] ir_o;
        logic [xroute_pkg::N_IR_IN-1:0] lir;
        logic cap_v;
        logic [PW-1:0] cap_p;
        logic [DW-1:0] cap_d;
        logic [xroute_pkg::N_IR_IN-1:0] ir_cap;
    } top_state_type;
    top_state_type st_q;
    top_state_type st_d;

    // ------------------------------------------------------------
    // departure from the hold stage
    // ------------------------------------------------------------
    logic fifo_in_ready;
    logic fifo_push;
    logic depart;
    logic [PW-1:0] dep_p;
    logic [NS-1:0][EW-1:0] loc_ev;
    logic [xroute_pkg::N_SER_REM-1:0][EW-1:0] rem_ev;
    logic [NS-1:0][xroute_pkg::N_SER_SRC-1:0][EW-1:0] ser_src;
    logic [NS-1:0][EW-1:0] ser_pick;
    logic [xroute_pkg::N_IR_SRC-1:0] ir_src;
    logic [xroute_pkg::N_IR_OUT-1:0][xroute_pkg::N_IR_SRC-1:0] ir_src_v;
    logic [xroute_pkg::N_IR_OUT-1:0] ir_pick;

    // round robin so one busy connector cannot starve the other
    always_comb begin
        dep_p = st_q.rr;
        if (!st_q.hold_v[st_q.rr]) begin
            dep_p = st_q.rr + 1'b1;
        end
    end
    // with the link down bytes still leave the hold for local routing
    assign depart = st_q.hold_v[dep_p] && (fifo_in_ready || !link_en);
    assign fifo_push = depart && link_en;

    link_fifo #(
        .WIDTH(xroute_pkg::LINK_W),
        .DEPTH(xroute_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({dep_p, st_q.hold_d[dep_p]}),
        .out_valid(link_valid),
        .out_ready(link_ready),
        .out_data(link_data)
    );

    // ------------------------------------------------------------
    // source events for the serial crosspoint
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NS; i++) begin
            loc_ev[i] = {depart && (dep_p == PW'(i)), st_q.hold_d[i]};
        end
        for (int k = 0; k < xroute_pkg::N_SER_REM; k++) begin
            rem_ev[k] = {rem_valid && link_en && (rem_port == PW'(k)), rem_data};
        end
        for (int j = 0; j < NS; j++) begin
            ser_src[j] = {rem_ev, loc_ev};
        end
    end

    genvar g;
    generate
        for (g = 0; g < NS; g++) begin : g_ser
            dest_sel #(
                .NSRC(xroute_pkg::N_SER_SRC),
                .SW(SW),
                .W(EW)
            ) u_sel (
                .en(st_q.ser_en[g]),
                .sel(st_q.ser_sel[g]),
                .src(ser_src[g]),
                .dout(ser_pick[g])
            );
        end
        for (g = 0; g < xroute_pkg::N_IR_OUT; g++) begin : g_ir
            dest_sel #(
                .NSRC(xroute_pkg::N_IR_SRC),
                .SW(SW),
                .W(1)
            ) u_sel (
                .en(st_q.ir_en[g]),
                .sel(st_q.ir_sel[g]),
                .src(ir_src_v[g]),
                .dout(ir_pick[g])
            );
        end
    endgenerate

    // remote infrared is ignored while this unit's link is off
    assign ir_src = {rem_ir & {xroute_pkg::N_IR_REM{link_en}}, ir_in};
    always_comb begin
        for (int j = 0; j < xroute_pkg::N_IR_OUT; j++) begin
            ir_src_v[j] = ir_src;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // hold stage: one byte per connector
        for (int i = 0; i < NS; i++) begin
            if (loc_ev[i][DW]) begin
                st_d.hold_v[i] = 1'b0;
            end
            if (tx_valid[i] && !st_q.hold_v[i]) begin
                st_d.hold_v[i] = 1'b1;
                st_d.hold_d[i] = tx_data[i];
            end
        end
        if (depart) begin
            st_d.rr = dep_p + 1'b1;
        end
        // local configuration picks the source of every local destination
        if (cfg_wr && !cfg_ir) begin
            st_d.ser_en[cfg_dest] = cfg_en;
            st_d.ser_sel[cfg_dest] = cfg_src;
        end
        if (cfg_wr && cfg_ir) begin
            st_d.ir_en[cfg_dest] = cfg_en;
            st_d.ir_sel[cfg_dest] = cfg_src;
        end
        // serial receive lines; routed bytes win, injection waits
        for (int j = 0; j < NS; j++) begin
            st_d.rx_v[j] = ser_pick[j][DW];
            st_d.rx_d[j] = ser_pick[j][DW-1:0];
        end
        if (st_q.ip_v && !ser_pick[st_q.ip_p][DW]) begin
            st_d.rx_v[st_q.ip_p] = 1'b1;
            st_d.rx_d[st_q.ip_p] = st_q.ip_d;
            st_d.ip_v = 1'b0;
        end
        if (ip_valid && !st_q.ip_v) begin
            st_d.ip_v = 1'b1;
            st_d.ip_p = ip_port;
            st_d.ip_d = ip_data;
        end
        // capture of local transmit bytes toward the ip port
        st_d.cap_v = depart;
        st_d.cap_p = dep_p;
        st_d.cap_d = st_q.hold_d[dep_p];
        // infrared
        for (int j = 0; j < xroute_pkg::N_IR_OUT; j++) begin
            st_d.ir_o[j] = ip_ir_en[j] ? ip_ir_data[j] : ir_pick[j];
        end
        st_d.lir = ir_in;
        st_d.ir_cap = ir_in;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tx_ready = ~st_q.hold_v;
    assign rx_valid = st_q.rx_v;
    assign rx_data = st_q.rx_d;
    assign ir_out = st_q.ir_o;
    assign link_ir = st_q.lir;
    assign ip_ready = ~st_q.ip_v;
    assign cap_valid = st_q.cap_v;
    assign cap_port = st_q.cap_p;
    assign cap_data = st_q.cap_d;
    assign ip_ir_cap = st_q.ir_cap;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_loop0;
        st_q.ser_en[0] && (st_q.ser_sel[0] == SW'(0)) && loc_ev[0][DW];
    endsequence
    sequence s_rem1;
        st_q.ser_en[1] && (st_q.ser_sel[1] == SW'(NS + 1)) && rem_ev[1][DW];
    endsequence
    sequence s_ip_take;
        ip_valid && ip_ready && !st_q.ser_en[ip_port] ##1 !ser_pick[st_q.ip_p][DW];
    endsequence
    sequence s_push;
        fifo_push;
    endsequence
    // ip bytes give way to routed ones, so only an idle destination proves the drop
    sequence s_rem_off0;
        st_q.ser_en[0] && (st_q.ser_sel[0] == SW'(2)) && rem_valid && !link_en && !st_q.ip_v;
    endsequence

    AST_RESET_OPEN: assert property ($past(rst) |-> st_q.ser_en == '0 && st_q.ir_en == '0)
        else $error("destination connected right after reset");
    AST_LOOPBACK: assert property (s_loop0 |=> rx_valid[0] && rx_data[0] == $past(st_q.hold_d[0]))
        else $error("serial loopback byte missing");
    AST_REMOTE_SRC: assert property (s_rem1 |=> rx_valid[1] && rx_data[1] == $past(rem_data))
        else $error("remote serial byte not routed");
    AST_FORWARD: assert property (s_push |=> !st_q.hold_v[$past(dep_p)] && link_valid)
        else $error("forwarded byte not released");
    AST_HOLD_DRAIN: assert property (st_q.hold_v[0] && !st_q.hold_v[1] && link_en && fifo_in_ready
        |=> !st_q.hold_v[0])
        else $error("held byte did not go to the link");
    AST_IP_INJECT: assert property (s_ip_take |=> rx_valid[$past(st_q.ip_p)])
        else $error("injected serial byte not delivered");
    AST_CFG_SEL: assert property (cfg_wr && !cfg_ir |=> st_q.ser_sel[$past(cfg_dest)] == $past(cfg_src))
        else $error("serial selection not stored");
    AST_IR_FWD: assert property (##1 link_ir == $past(ir_in))
        else $error("infrared not forwarded");
    AST_IR_LOOP: assert property (st_q.ir_en[0] && st_q.ir_sel[0] == SW'(0) && !ip_ir_en[0]
        |=> ir_out[0] == $past(ir_in[0]))
        else $error("infrared loopback wrong");
    AST_IR_LINK_OFF: assert property (st_q.ir_en[1] && st_q.ir_sel[1] >= SW'(2) && !link_en
        && !ip_ir_en[1] |=> !ir_out[1])
        else $error("remote infrared passed with link off");
    AST_IR_INJECT: assert property (ip_ir_en[1] |=> ir_out[1] == $past(ip_ir_data[1]))
        else $error("infrared injection wrong");
    AST_CAP_PUSH: assert property (s_push |=> cap_valid)
        else $error("pushed byte not captured");
    AST_TX_TAKE: assert property (tx_valid[0] && tx_ready[0] |=> !tx_ready[0])
        else $error("taken byte did not fill the hold");
    AST_REM_DROP: assert property (s_rem_off0 |=> !rx_valid[0])
        else $error("remote byte passed with link off");
    AST_SER_OPEN: assert property (!st_q.ser_en[1] && !st_q.ip_v |=> !rx_valid[1])
        else $error("unconnected serial destination active");
    AST_IR_OPEN: assert property (!st_q.ir_en[0] && !ip_ir_en[0] |=> !ir_out[0])
        else $error("unconnected infrared destination active");
endmodule // xroute_top

// >>> sim/remote_model.sv
// behavioural far-end extender: link sink, remote serial source, remote infrared
`timescale 1ns/1ns
module remote_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_valid,
    output logic link_ready,
    input wire logic [xroute_pkg::LINK_W-1:0] link_data,
    output logic rem_valid,
    output logic [xroute_pkg::PORT_W-1:0] rem_port,
    output logic [xroute_pkg::DATA_W-1:0] rem_data,
    output logic [xroute_pkg::N_IR_REM-1:0] rem_ir
);
    logic stall;
    logic [xroute_pkg::LINK_W-1:0] rcv[$];
    initial begin
        stall = 1'b0;
        link_ready = 1'b1;
        rem_valid = 1'b0;
        rem_port = 1'h0;
        rem_data = 8'h5A;
        rem_ir = 2'h0;
    end
    // slow far end: ready withdrawn while stalled
    always @(negedge clock) begin
        link_ready <= !stall;
    end
    // a word is recorded only in a cycle where link_valid and link_ready are both high
    always @(posedge clock) begin
        if (!rst && link_valid === 1'b1 && link_ready)
            rcv.push_back(link_data);
    end
    task automatic send(input logic [0:0] p, input logic [7:0] d);
        @(negedge clock);
        rem_valid = 1'b1;
        rem_port = p;
        rem_data = d;
        @(negedge clock);
        rem_valid = 1'b0;
        // released line must not keep showing the byte
        rem_data = ~d;
    endtask
endmodule // remote_model

// >>> sim/test_xroute_top.sv
// self-checking bench for the serial and infrared crosspoint
`timescale 1ns/1ns
module test_xroute_top;
    logic clock, rst, link_en, link_valid, link_ready, rem_valid;
    logic [1:0] tx_valid, tx_ready, rx_valid, ir_in, ir_out, link_ir, rem_ir;
    logic [1:0][7:0] tx_data, rx_data;
    logic [8:0] link_data;
    logic [0:0] rem_port, cfg_dest, ip_port, cap_port;
    logic [7:0] rem_data, ip_data, cap_data;
    logic cfg_wr, cfg_ir, cfg_en, ip_valid, ip_ready, cap_valid;
    logic [1:0] cfg_src, ip_ir_en, ip_ir_data, ip_ir_cap;
    logic [8:0] cap_last;
    int failures = 0;
    int checks_done = 0;

    xroute_top xroute_top_inst (.clock(clock), .rst(rst), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
        .ir_in(ir_in), .ir_out(ir_out), .link_en(link_en), .link_valid(link_valid),
        .link_ready(link_ready), .link_data(link_data), .rem_valid(rem_valid),
        .rem_port(rem_port), .rem_data(rem_data), .link_ir(link_ir), .rem_ir(rem_ir),
        .cfg_wr(cfg_wr), .cfg_ir(cfg_ir), .cfg_dest(cfg_dest), .cfg_en(cfg_en),
        .cfg_src(cfg_src), .ip_valid(ip_valid), .ip_ready(ip_ready), .ip_port(ip_port),
        .ip_data(ip_data), .cap_valid(cap_valid), .cap_port(cap_port),
        .cap_data(cap_data), .ip_ir_en(ip_ir_en), .ip_ir_data(ip_ir_data),
        .ip_ir_cap(ip_ir_cap));
    remote_model remote_model_inst (.clock(clock), .rst(rst), .link_valid(link_valid),
        .link_ready(link_ready), .link_data(link_data), .rem_valid(rem_valid),
        .rem_port(rem_port), .rem_data(rem_data), .rem_ir(rem_ir));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(negedge clock) begin
        if (cap_valid === 1'b1)
            cap_last <= {cap_port, cap_data};
    end

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cfg(input logic ir, input logic d, input logic e, input logic [1:0] s);
        @(negedge clock);
        {cfg_wr, cfg_ir, cfg_dest, cfg_en, cfg_src} = {1'b1, ir, d, e, s};
        @(negedge clock);
        cfg_wr = 1'b0;
    endtask
    task automatic send_tx(input int p, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clock);
        tx_valid[p] = 1'b1;
        tx_data[p] = d;
        while (tx_ready[p] !== 1'b1 && n < 60) begin
            @(negedge clock);
            n++;
        end
        check(n < 60, 1'b1);
        @(negedge clock);
        tx_valid[p] = 1'b0;
        tx_data[p] = ~d;
    endtask
    task automatic ip_send(input logic p, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clock);
        {ip_valid, ip_port, ip_data} = {1'b1, p, d};
        while (ip_ready !== 1'b1 && n < 60) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        ip_valid = 1'b0;
        ip_data = ~d;
    endtask
    task automatic wait_rx(input int d, input logic [7:0] exp, input logic want);
        logic found;
        found = 1'b0;
        repeat (20) begin
            @(negedge clock);
            if (rx_valid[d] === 1'b1 && !found) begin
                found = 1'b1;
                check(rx_data[d], exp);
            end
        end
        check(found, want);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check({tx_ready, ip_ready}, 3'b111);
        check({rx_valid, ir_out, link_valid, cap_valid}, 6'h00);
        $display("test reset done");
    endtask
    task automatic t_matrix();
        logic [7:0] b;
        for (int d = 0; d < 2; d++) begin
            for (int s = 0; s < 4; s++) begin
                b = 8'hA0 + 8'(d * 4 + s);
                cfg(1'b0, d[0], 1'b1, s[1:0]);
                if (s < 2) begin
                    fork
                        send_tx(s, b);
                        wait_rx(d, b, 1'b1);
                    join
                    check(cap_last, {s[0], b});
                    check(remote_model_inst.rcv[$], {s[0], b});
                end else begin
                    fork
                        remote_model_inst.send(s[0], b);
                        wait_rx(d, b, 1'b1);
                    join
                end
            end
        end
        $display("test matrix done");
    endtask
    task automatic t_fifo();
        remote_model_inst.rcv.delete();
        remote_model_inst.stall = 1'b1;
        for (int i = 0; i < 9; i++)
            send_tx(0, 8'h10 + 8'(i));
        fork
            send_tx(0, 8'h19);
            begin
                repeat (10) @(negedge clock);
                check(tx_ready[0], 1'b0);
                check(link_valid, 1'b1);
                remote_model_inst.stall = 1'b0;
            end
        join
        repeat (30) @(negedge clock);
        check(remote_model_inst.rcv.size(), 10);
        for (int i = 0; i < 10; i++)
            check(remote_model_inst.rcv[i], {1'b0, 8'h10 + 8'(i)});
        $display("test fifo done");
    endtask
    task automatic t_link_off();
        remote_model_inst.rcv.delete();
        link_en = 1'b0;
        cfg(1'b0, 1'b1, 1'b1, 2'h1);
        fork
            send_tx(1, 8'h77);
            wait_rx(1, 8'h77, 1'b1);
        join
        check(remote_model_inst.rcv.size(), 0);
        cfg(1'b0, 1'b0, 1'b1, 2'h2);
        fork
            remote_model_inst.send(1'b0, 8'h66);
            wait_rx(0, 8'h66, 1'b0);
        join
        link_en = 1'b1;
        cfg(1'b0, 1'b0, 1'b0, 2'h0);
        fork
            send_tx(0, 8'h33);
            wait_rx(0, 8'h33, 1'b0);
        join
        fork
            ip_send(1'b1, 8'hC5);
            wait_rx(1, 8'hC5, 1'b1);
        join
        fork
            ip_send(1'b0, 8'h3C);
            wait_rx(0, 8'h3C, 1'b1);
        join
        $display("test link and ip done");
    endtask
    task automatic t_ir();
        @(negedge clock);
        ir_in = 2'b01;
        @(negedge clock);
        check(link_ir, 2'b01);
        check(ip_ir_cap, 2'b01);
        cfg(1'b1, 1'b0, 1'b1, 2'h0);
        cfg(1'b1, 1'b1, 1'b1, 2'h3);
        remote_model_inst.rem_ir = 2'b10;
        repeat (3) @(negedge clock);
        check(ir_out, 2'b11);
        ir_in = 2'b00;
        remote_model_inst.rem_ir = 2'b00;
        repeat (3) @(negedge clock);
        check(ir_out, 2'b00);
        {ip_ir_en, ip_ir_data} = 4'b0101;
        repeat (3) @(negedge clock);
        check(ir_out, 2'b01);
        {ip_ir_en, ip_ir_data} = 4'b1010;
        repeat (3) @(negedge clock);
        check(ir_out, 2'b10);
        ip_ir_en = 2'b00;
        link_en = 1'b0;
        remote_model_inst.rem_ir = 2'b10;
        repeat (3) @(negedge clock);
        check(ir_out, 2'b00);
        link_en = 1'b1;
        repeat (3) @(negedge clock);
        check(ir_out, 2'b10);
        remote_model_inst.rem_ir = 2'b00;
        $display("test infrared done");
    endtask

    initial begin
        {rst, link_en, tx_valid, tx_data, ir_in, cfg_wr, cfg_ir} = {1'b1, 1'b1, 22'h0};
        {cfg_dest, cfg_en, cfg_src, ip_valid, ip_port, ip_data} = 14'h0;
        {ip_ir_en, ip_ir_data, cap_last} = 13'h0;
        repeat (10) @(negedge clock);
        t_reset();
        rst = 1'b0;
        t_reset();
        t_matrix();
        t_fifo();
        t_link_off();
        t_ir();
        give_verdict();
    end
    // whole run needs about 400 cycles
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule // test_xroute_top
